// ==== rtl/lmrt_consts.svh ====
// constants for the load model and relaxation tracker
`ifndef LMRT_CONSTS_SVH
`define LMRT_CONSTS_SVH
`define LMRT_OFS_CFG 6'h00
`define LMRT_OFS_STATUS 6'h04
`define LMRT_OFS_FLOW_THR 6'h08
`define LMRT_OFS_QUIT 6'h0c
`define LMRT_OFS_RELAX_T 6'h10
`define LMRT_OFS_HYP_RATE 6'h14
`define LMRT_OFS_USER_RATE 6'h18
`define LMRT_OFS_RESERVE 6'h1c
`define LMRT_OFS_QMAX 6'h20
`define LMRT_OFS_LEARN 6'h24
`define LMRT_OFS_LAST_RUN 6'h28
`define LMRT_OFS_RATE 6'h2c
`define LMRT_CFG_MODE_BIT 0
`define LMRT_CFG_SEL_LSB 4
`define LMRT_LEARN_BIT 0
`define LMRT_RST_MODE 1'h0
`define LMRT_RST_SEL 3'h1
`define LMRT_RST_DSG_THR 16'h003c
`define LMRT_RST_CHG_THR 16'h004b
`define LMRT_RST_QUIT 16'h0028
`define LMRT_RST_DSG_RELAX 13'h003c
`define LMRT_RST_CHG_RELAX 8'h3c
`define LMRT_RST_QUIT_RELAX 6'h01
`define LMRT_RST_QMAX 16'h03e8
`define LMRT_RST_AVG_I 16'hfed5
`define LMRT_RST_AVG_P 16'hfb95
`define LMRT_SECOND_NS 1000000000
`define LMRT_CLOCK_NS 100
`define LMRT_FILT_TAU_S 14
`define LMRT_OCV_WAIT_S 300
`define LMRT_SLOPE_MAX_UV 4
`define LMRT_RATE_DIV 5
`define LMRT_POWER_DIV 10000
`endif

// ==== rtl/lmrt_pkg.sv ====
// types shared by the load model and relaxation tracker
package lmrt_pkg;
	typedef enum logic [1:0] {
		LMRT_ACTIVE = 2'b00,
		LMRT_RELAX = 2'b01
	} lmrt_relax_type;
	typedef struct packed {
		logic signed [15:0] mean_current;
		logic [15:0] voltage;
		logic [15:0] volt_slope;
		logic [15:0] design_cap;
		logic [15:0] design_energy;
	} lmrt_meas_type;
	typedef struct packed {
		logic new_a;
		logic new_b;
		logic signed [15:0] qmax_value;
	} lmrt_learn_type;
	typedef struct packed {
		logic signed [15:0] rate;
		logic [15:0] reserve_charge;
		logic [15:0] reserve_energy;
		logic signed [15:0] qmax_a;
		logic signed [15:0] qmax_b;
		logic load_model;
		logic dsg_flow;
		logic chg_flow;
		logic relaxed;
		logic ocv_enable;
		logic qmax_update_ok;
	} lmrt_out_type;
endpackage

// ==== rtl/lmrt_top.sv ====
// load model selection, flow detection and relaxation tracking
`timescale 1ns/100ps
`include "lmrt_consts.svh"
// Overview of operation
// - load mode 0 picks constant-current model, 1 constant-power; default 0
// - load model status bit always mirrors the load mode setting
// - current select 0 uses previous discharge cycle average current
// - current select 1, default, uses running average of present cycle
// - select 2 uses mean current, select 3 its 14 s filtered value
// - current select 4 uses design capacity divided by five
// - select 5 uses hypothetical rate, select 6 user current rate
// - power select 0 previous cycle power, 1 present cycle average
// - power select 2 mean current times voltage, 3 filtered times voltage
// - power select 4 energy/5, 5 hypothetical rate, 6 user power rate
// - keep configurable reserve charge for the no-load compensation
// - keep configurable reserve energy for the no-load compensation
// - discharge flows only when its magnitude exceeds discharge threshold
// - charge flows only when its magnitude exceeds charge threshold
// - enter relax when mean current below quit for either relax time
// - after five minutes relaxed, allow open-circuit voltage readings
// - allow capacity update only if voltage slope below 4 uV/s too
// - leave relax only after current above quit for quit relax time
// - hold two capacity values, host initialised, device updated
// - bit 0 of each learn status set on learning; others reserved
// - log average current per discharge cycle, keep previous value
module lmrt_top
	import lmrt_pkg::*;
#(
	parameter int unsigned CYCLES_PER_SECOND =
		`LMRT_SECOND_NS / `LMRT_CLOCK_NS
)(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	input wire lmrt_meas_type i_meas,
	input wire lmrt_learn_type i_learn,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	output lmrt_out_type o_out
);
	logic load_mode_r;
	logic [2:0] load_sel_r;
	logic [15:0] dsg_thr_r, chg_thr_r, quit_r;
	logic [12:0] dsg_relax_r;
	logic [7:0] chg_relax_r;
	logic [5:0] quit_relax_r;
	logic signed [15:0] hyp_rate_r, user_i_r, user_p_r;
	logic [15:0] res_chg_r, res_nrg_r;
	logic signed [15:0] qmax_a_r, qmax_b_r;
	logic learn_a_r, learn_b_r;
	logic signed [15:0] last_i_r, last_p_r;
	logic wr_pend_r;
	logic [5:0] wr_addr_r;
	logic [23:0] tick_cnt_r;
	logic tick_r;
	logic signed [15:0] filt_r;
	logic signed [39:0] sum_i_r, sum_p_r;
	logic [23:0] run_cnt_r;
	logic in_cycle_r;
	logic below_prev_r;
	logic [12:0] secs_r;
	logic [8:0] relax_secs_r;
	lmrt_relax_type relax_st_r;
	logic [31:0] rd_nxt;
	logic signed [15:0] rate_nxt, mean_p, filt_p, run_i, run_p;
	logic [15:0] mean_abs;
	logic below, dsg_now, chg_now, addr_ok;
	logic wr_learn, rd_take;

	function automatic logic [15:0] lmrt_abs(input logic signed [15:0] x);
		lmrt_abs = x[15] ? 16'(-x) : 16'(x);
	endfunction

	function automatic logic signed [15:0] lmrt_avg(
		input logic signed [39:0] s,
		input logic [23:0] n
	);
		logic signed [39:0] q;
		q = 40'sh0;
		if (n != 24'h0)
			q = s / $signed({16'h0000, n});
		lmrt_avg = q[15:0];
	endfunction

	function automatic logic signed [15:0] lmrt_pwr(
		input logic signed [15:0] i,
		input logic [15:0] v
	);
		logic signed [32:0] m;
		m = i * $signed({1'b0, v});
		m = m / 33'sd`LMRT_POWER_DIV;
		lmrt_pwr = m[15:0];
	endfunction

	assign mean_abs = lmrt_abs(i_meas.mean_current);
	// sign convention: discharge is negative current
	assign dsg_now = i_meas.mean_current[15] && mean_abs > dsg_thr_r;
	assign chg_now = !i_meas.mean_current[15] &&
		mean_abs > chg_thr_r;
	assign below = mean_abs < quit_r;
	assign mean_p = lmrt_pwr(i_meas.mean_current, i_meas.voltage);
	assign filt_p = lmrt_pwr(filt_r, i_meas.voltage);
	assign run_i = lmrt_avg(sum_i_r, run_cnt_r);
	assign run_p = lmrt_avg(sum_p_r, run_cnt_r);
	assign addr_ok = i_hsel && i_htrans[1] && i_hready;
	assign rd_take = addr_ok && !i_hwrite;
	assign wr_learn = wr_pend_r && wr_addr_r == `LMRT_OFS_LEARN;

	// zero wait states: the read word is latched in the address phase,
	// so a read right after a write to the same word sees the old value
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 6'h00;
			o_hrdata <= 32'h0000_0000;
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
		end
		else
		begin
			wr_pend_r <= addr_ok && i_hwrite && i_haddr[31:6] == 26'h0;
			wr_addr_r <= {i_haddr[5:2], 2'b00};
			if (rd_take)
				o_hrdata <= rd_nxt;
		end
	end

	always_comb
	begin
		rd_nxt = 32'h0000_0000;
		if (i_haddr[31:6] == 26'h0)
		begin
			unique case ({i_haddr[5:2], 2'b00})
				`LMRT_OFS_CFG: rd_nxt = {25'h0, load_sel_r, 3'h0, load_mode_r};
				`LMRT_OFS_STATUS: rd_nxt = {26'h0, o_out.qmax_update_ok,
					o_out.ocv_enable, o_out.relaxed, o_out.chg_flow,
					o_out.dsg_flow, o_out.load_model};
				`LMRT_OFS_FLOW_THR: rd_nxt = {chg_thr_r, dsg_thr_r};
				`LMRT_OFS_QUIT: rd_nxt = {16'h0, quit_r};
				`LMRT_OFS_RELAX_T: rd_nxt = {2'h0, quit_relax_r, chg_relax_r,
					3'h0, dsg_relax_r};
				`LMRT_OFS_HYP_RATE: rd_nxt = {16'h0, hyp_rate_r};
				`LMRT_OFS_USER_RATE: rd_nxt = {user_p_r, user_i_r};
				`LMRT_OFS_RESERVE: rd_nxt = {res_nrg_r, res_chg_r};
				`LMRT_OFS_QMAX: rd_nxt = {qmax_b_r, qmax_a_r};
				`LMRT_OFS_LEARN: rd_nxt = {23'h0, learn_b_r, 7'h0, learn_a_r};
				`LMRT_OFS_LAST_RUN: rd_nxt = {last_p_r, last_i_r};
				`LMRT_OFS_RATE: rd_nxt = {16'h0, o_out.rate};
				default: rd_nxt = 32'h0000_0000;
			endcase
		end
	end

	// host configuration words
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			load_mode_r <= `LMRT_RST_MODE;
			load_sel_r <= `LMRT_RST_SEL;
			dsg_thr_r <= `LMRT_RST_DSG_THR;
			chg_thr_r <= `LMRT_RST_CHG_THR;
			quit_r <= `LMRT_RST_QUIT;
			dsg_relax_r <= `LMRT_RST_DSG_RELAX;
			chg_relax_r <= `LMRT_RST_CHG_RELAX;
			quit_relax_r <= `LMRT_RST_QUIT_RELAX;
			hyp_rate_r <= 16'h0000;
			user_i_r <= 16'h0000;
			user_p_r <= 16'h0000;
			res_chg_r <= 16'h0000;
			res_nrg_r <= 16'h0000;
		end
		else if (wr_pend_r)
		begin
			unique case (wr_addr_r)
				`LMRT_OFS_CFG:
				begin
					load_mode_r <= i_hwdata[`LMRT_CFG_MODE_BIT];
					load_sel_r <= i_hwdata[`LMRT_CFG_SEL_LSB +: 3];
				end
				`LMRT_OFS_FLOW_THR:
				begin
					dsg_thr_r <= i_hwdata[15:0];
					chg_thr_r <= i_hwdata[31:16];
				end
				`LMRT_OFS_QUIT: quit_r <= i_hwdata[15:0];
				`LMRT_OFS_RELAX_T:
				begin
					dsg_relax_r <= i_hwdata[12:0];
					chg_relax_r <= i_hwdata[23:16];
					quit_relax_r <= i_hwdata[29:24];
				end
				`LMRT_OFS_HYP_RATE: hyp_rate_r <= i_hwdata[15:0];
				`LMRT_OFS_USER_RATE:
				begin
					user_i_r <= i_hwdata[15:0];
					user_p_r <= i_hwdata[31:16];
				end
				`LMRT_OFS_RESERVE:
				begin
					res_chg_r <= i_hwdata[15:0];
					res_nrg_r <= i_hwdata[31:16];
				end
				default:
				begin
				end
			endcase
		end
	end

	// capacity values and learn flags; a learn event beats a host write
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			qmax_a_r <= `LMRT_RST_QMAX;
			qmax_b_r <= `LMRT_RST_QMAX;
			learn_a_r <= 1'b0;
			learn_b_r <= 1'b0;
		end
		else
		begin
			if (i_learn.new_a)
				qmax_a_r <= i_learn.qmax_value;
			else if (wr_pend_r && wr_addr_r == `LMRT_OFS_QMAX)
				qmax_a_r <= i_hwdata[15:0];
			if (i_learn.new_b)
				qmax_b_r <= i_learn.qmax_value;
			else if (wr_pend_r && wr_addr_r == `LMRT_OFS_QMAX)
				qmax_b_r <= i_hwdata[31:16];
			if (i_learn.new_a)
				learn_a_r <= 1'b1;
			else if (wr_learn)
				learn_a_r <= i_hwdata[`LMRT_LEARN_BIT];
			if (i_learn.new_b)
				learn_b_r <= 1'b1;
			else if (wr_learn)
				learn_b_r <= i_hwdata[8 + `LMRT_LEARN_BIT];
		end
	end

	// one-second tick drives the filter, averages and relax timers
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			tick_cnt_r <= 24'h0;
			tick_r <= 1'b0;
		end
		else
		begin
			tick_r <= tick_cnt_r == 24'(CYCLES_PER_SECOND - 1);
			if (tick_cnt_r == 24'(CYCLES_PER_SECOND - 1))
				tick_cnt_r <= 24'h0;
			else
				tick_cnt_r <= tick_cnt_r + 24'h1;
		end
	end

	// first-order filter, step of one tau-th per second
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			filt_r <= 16'h0000;
		else if (tick_r)
			filt_r <= filt_r + 16'(($signed({i_meas.mean_current[15],
				i_meas.mean_current}) - $signed({filt_r[15], filt_r})) /
				17'sd`LMRT_FILT_TAU_S);
	end

	// discharge cycle averages, kept as the previous run when it ends
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			sum_i_r <= 40'sh0;
			sum_p_r <= 40'sh0;
			run_cnt_r <= 24'h0;
			in_cycle_r <= 1'b0;
			last_i_r <= `LMRT_RST_AVG_I;
			last_p_r <= `LMRT_RST_AVG_P;
		end
		else
		begin
			in_cycle_r <= dsg_now;
			if (dsg_now && !in_cycle_r)
			begin
				sum_i_r <= 40'sh0;
				sum_p_r <= 40'sh0;
				run_cnt_r <= 24'h0;
			end
			else if (dsg_now && tick_r)
			begin
				sum_i_r <= sum_i_r + 40'(i_meas.mean_current);
				sum_p_r <= sum_p_r + 40'(mean_p);
				run_cnt_r <= run_cnt_r + 24'h1;
			end
			if (!dsg_now && in_cycle_r && run_cnt_r != 24'h0)
			begin
				last_i_r <= run_i;
				last_p_r <= run_p;
			end
		end
	end

	// seconds since the quit comparison last changed
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			below_prev_r <= 1'b0;
			secs_r <= 13'h0;
		end
		else
		begin
			below_prev_r <= below;
			if (below != below_prev_r)
				secs_r <= 13'h0;
			else if (tick_r && secs_r != 13'h1fff)
				secs_r <= secs_r + 13'h1;
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			relax_st_r <= LMRT_ACTIVE;
		else
		begin
			unique case (relax_st_r)
				LMRT_ACTIVE:
					if (below && below == below_prev_r &&
						(secs_r >= dsg_relax_r || secs_r >= 13'(chg_relax_r)))
						relax_st_r <= LMRT_RELAX;
				LMRT_RELAX:
					if (!below && !below_prev_r &&
						secs_r >= 13'(quit_relax_r))
						relax_st_r <= LMRT_ACTIVE;
				default: relax_st_r <= LMRT_ACTIVE;
			endcase
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst || relax_st_r != LMRT_RELAX)
			relax_secs_r <= 9'h0;
		else if (tick_r && relax_secs_r != 9'(`LMRT_OCV_WAIT_S))
			relax_secs_r <= relax_secs_r + 9'h1;
	end

	always_comb
	begin
		rate_nxt = run_i;
		if (!load_mode_r)
		begin
			unique case (load_sel_r)
				3'h0: rate_nxt = last_i_r;
				3'h2: rate_nxt = i_meas.mean_current;
				3'h3: rate_nxt = filt_r;
				3'h4: rate_nxt = 16'(i_meas.design_cap / `LMRT_RATE_DIV);
				3'h5: rate_nxt = hyp_rate_r;
				3'h6: rate_nxt = user_i_r;
				default: rate_nxt = run_i;
			endcase
		end
		else
		begin
			unique case (load_sel_r)
				3'h0: rate_nxt = last_p_r;
				3'h2: rate_nxt = mean_p;
				3'h3: rate_nxt = filt_p;
				3'h4: rate_nxt = 16'(i_meas.design_energy /
					`LMRT_RATE_DIV);
				3'h5: rate_nxt = hyp_rate_r;
				3'h6: rate_nxt = user_p_r;
				default: rate_nxt = run_p;
			endcase
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			o_out <= '0;
		else
		begin
			o_out.rate <= rate_nxt;
			o_out.reserve_charge <= res_chg_r;
			o_out.reserve_energy <= res_nrg_r;
			o_out.qmax_a <= qmax_a_r;
			o_out.qmax_b <= qmax_b_r;
			o_out.load_model <= load_mode_r;
			o_out.dsg_flow <= dsg_now;
			o_out.chg_flow <= chg_now;
			o_out.relaxed <= relax_st_r == LMRT_RELAX;
			o_out.ocv_enable <= relax_st_r == LMRT_RELAX &&
				relax_secs_r == 9'(`LMRT_OCV_WAIT_S);
			o_out.qmax_update_ok <= relax_st_r == LMRT_RELAX &&
				relax_secs_r == 9'(`LMRT_OCV_WAIT_S) &&
				i_meas.volt_slope < 16'(`LMRT_SLOPE_MAX_UV);
		end
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	sequence s_rising_above;
		relax_st_r == LMRT_RELAX && !below && !below_prev_r;
	endsequence
	sequence s_too_soon;
		secs_r < 13'(quit_relax_r);
	endsequence

	a_mode_mirror: assert property (
		##1 o_out.load_model == $past(load_mode_r))
		else $error("load model status bit does not mirror mode");
	a_cc_user_rate: assert property (
		(!load_mode_r && load_sel_r == 3'h6) |=>
		o_out.rate == $past(user_i_r))
		else $error("user current rate not selected");
	a_cc_cap_fifth: assert property (
		(!load_mode_r && load_sel_r == 3'h4) |=>
		o_out.rate == 16'($past(i_meas.design_cap) / `LMRT_RATE_DIV))
		else $error("design capacity fifth not selected");
	a_cp_hyp_rate: assert property (
		(load_mode_r && load_sel_r == 3'h5) |=>
		o_out.rate == $past(hyp_rate_r))
		else $error("hypothetical power rate not selected");
	a_dsg_flow_flag: assert property (
		##1 o_out.dsg_flow == ($past(i_meas.mean_current[15]) &&
		lmrt_abs($past(i_meas.mean_current)) > $past(dsg_thr_r)))
		else $error("discharge flow flag wrong");
	a_chg_flow_flag: assert property (
		o_out.chg_flow |-> !$past(i_meas.mean_current[15]) &&
		lmrt_abs($past(i_meas.mean_current)) > $past(chg_thr_r))
		else $error("charge flow flag wrong");
	a_relax_entry_hold: assert property (
		(relax_st_r == LMRT_ACTIVE && !below) |=>
		relax_st_r == LMRT_ACTIVE)
		else $error("relax entered while current above quit");
	a_relax_exit_hold: assert property (
		(s_rising_above and s_too_soon) |=> relax_st_r == LMRT_RELAX)
		else $error("relax left before quit relax time");
	a_ocv_wait: assert property (
		(relax_secs_r < 9'(`LMRT_OCV_WAIT_S)) |=> !o_out.ocv_enable)
		else $error("ocv readings allowed too early");
	a_qmax_slope: assert property (
		o_out.qmax_update_ok |-> o_out.ocv_enable &&
		$past(i_meas.volt_slope) < 16'(`LMRT_SLOPE_MAX_UV))
		else $error("capacity update allowed with steep slope");
	a_learn_set: assert property (i_learn.new_a |=> learn_a_r)
		else $error("learn flag not set");
	a_timer_restart: assert property (
		(below != below_prev_r) |=> secs_r == 13'h0)
		else $error("relax timer not restarted");
	a_bus_okay: assert property (o_hreadyout && !o_hresp)
		else $error("bus slave not ready or not okay");
endmodule

// ==== verif/lmrt_host_model.sv ====
// host-side bus master model that drives the register port
`timescale 1ns/100ps
module lmrt_host_model
(
	input wire logic i_clock,
	input wire logic i_hready,
	input wire logic [31:0] i_hrdata,
	output logic o_hsel,
	output logic [31:0] o_haddr,
	output logic [1:0] o_htrans,
	output logic o_hwrite,
	output logic [2:0] o_hsize,
	output logic [31:0] o_hwdata
);
	initial
	begin
		o_hsel = 1'b1;
		o_haddr = 32'h0;
		o_htrans = 2'h0;
		o_hwrite = 1'b0;
		o_hsize = 3'h2;
		o_hwdata = 32'h0;
	end

	// the host never writes the learned-status or last-run words on its own;
	// only explicit bench calls reach them
	task automatic xfer(input logic wr, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge i_clock);
		o_haddr <= a;
		o_htrans <= 2'h2;
		o_hwrite <= wr;
		@(posedge i_clock);
		while (i_hready !== 1'b1)
			@(posedge i_clock);
		o_htrans <= 2'h0;
		o_hwdata <= d;
		@(posedge i_clock);
		while (i_hready !== 1'b1)
			@(posedge i_clock);
		q = i_hrdata;
	endtask
endmodule

// ==== verif/lmrt_top_tb_top.sv ====
// self-checking bench for the load model and relaxation tracker
`timescale 1ns/100ps
module lmrt_top_tb_top
	import lmrt_pkg::*;
;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	lmrt_meas_type meas = {16'sd50, 16'd4000, 16'd2, 16'd1000, 16'd3700};
	lmrt_learn_type lrn = '0;
	lmrt_out_type out;
	int err_total = 0;
	int n_checks = 0;
	logic [31:0] ra[7] = '{32'h00, 32'h08, 32'h0c, 32'h10, 32'h20, 32'h24,
		32'h28};
	logic [31:0] rv[7] = '{32'h10, 32'h004b003c, 32'h28, 32'h013c003c,
		32'h03e803e8, 32'h0, 32'hfb95fed5};
	logic signed [15:0] ev[14] = '{-16'sd299, 0, 50, 0, 200, 321, 88,
		-16'sd1131, 0, 20, 0, 740, 321, 77};
	logic signed [15:0] fm[5] = '{-16'sd60, -16'sd61, 75, 76, 0};
	logic [31:0] q;

	always #50 clock = ~clock;

	lmrt_host_model u_host (
		.i_clock(clock),
		.i_hready(hreadyout),
		.i_hrdata(hrdata),
		.o_hsel(hsel),
		.o_haddr(haddr),
		.o_htrans(htrans),
		.o_hwrite(hwrite),
		.o_hsize(hsize),
		.o_hwdata(hwdata)
	);

	// one second is shortened to ten clocks so relax windows stay short
	lmrt_top #(.CYCLES_PER_SECOND(10)) u_dut (
		.i_clock(clock),
		.i_rst(rst),
		.i_hsel(hsel),
		.i_haddr(haddr),
		.i_htrans(htrans),
		.i_hwrite(hwrite),
		.i_hsize(hsize),
		.i_hwdata(hwdata),
		.i_hready(hreadyout),
		.i_meas(meas),
		.i_learn(lrn),
		.o_hrdata(hrdata),
		.o_hreadyout(hreadyout),
		.o_hresp(hresp),
		.o_out(out)
	);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD %0t %s: got %h want %h", $time, m, got, exp);
		end
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		u_host.xfer(1'b1, a, d, r);
	endtask

	task automatic rchk(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] r;
		u_host.xfer(1'b0, a, 32'h0, r);
		chk(r, e, "read");
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic mean(input logic signed [15:0] i);
		@(posedge clock);
		meas.mean_current <= i;
	endtask

	task automatic pulse(input logic b, input logic signed [15:0] v);
		@(posedge clock);
		lrn.new_a <= !b;
		lrn.new_b <= b;
		lrn.qmax_value <= v;
		@(posedge clock);
		lrn.new_a <= 1'b0;
		lrn.new_b <= 1'b0;
	endtask

	task automatic end_of_test;
		if (err_total == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// whole run needs about 3500 clocks
	initial
	begin
		repeat (20000) @(posedge clock);
		err_total++;
		end_of_test;
	end

	initial
	begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		cyc(2);
		chk(out.load_model, 1'b0, "load model default");
		for (int k = 0; k < 7; k++)
			rchk(ra[k], rv[k]);
		wr(32'h14, 32'd321);
		wr(32'h18, {16'd77, 16'd88});
		wr(32'h1c, {16'd9, 16'd8});
		cyc(3);
		chk(out.reserve_charge, 16'd8, "reserve charge");
		chk(out.reserve_energy, 16'd9, "reserve energy");
		for (int md = 0; md < 2; md++)
			for (int s = 0; s < 7; s++)
			begin
				if (s == 1 || s == 3)
					continue;
				wr(32'h0, 32'(s * 16 + md));
				cyc(3);
				chk(out.rate, ev[md * 7 + s], "rate");
				chk(out.load_model, md[0], "model out");
				u_host.xfer(1'b0, 32'h4, 32'h0, q);
				chk(q[0], md[0], "model status");
			end
		// one discharge run at a constant load gives exact averages
		wr(32'h0, 32'h10);
		mean(-16'sd600);
		cyc(60);
		chk(out.dsg_flow, 1'b1, "dsg flow");
		chk(out.rate, -16'sd600, "run avg current");
		// filtered current lags the step: negative but not yet at the load
		wr(32'h0, 32'h30);
		cyc(3);
		chk(out.rate[15], 1'b1, "filter sign");
		chk(out.rate > -16'sd600, 1'b1, "filter lag");
		wr(32'h0, 32'h11);
		cyc(3);
		chk(out.rate, -16'sd240, "run avg power");
		mean(16'sd0);
		cyc(5);
		rchk(32'h28, 32'hff10fda8);
		wr(32'h28, 32'h0);
		rchk(32'h28, 32'hff10fda8);
		wr(32'h0, 32'h00);
		cyc(3);
		chk(out.rate, -16'sd600, "last avg current");
		wr(32'h0, 32'h01);
		cyc(3);
		chk(out.rate, -16'sd240, "last avg power");
		for (int k = 0; k < 5; k++)
		begin
			mean(fm[k]);
			cyc(3);
			chk(out.dsg_flow, fm[k] < -16'sd60, "dsg edge");
			chk(out.chg_flow, fm[k] > 16'sd75, "chg edge");
		end
		wr(32'h10, 32'h03050003);
		mean(16'sd10);
		cyc(15);
		chk(out.relaxed, 1'b0, "early relax");
		cyc(30);
		chk(out.relaxed, 1'b1, "relax entry");
		cyc(2700);
		chk(out.ocv_enable, 1'b0, "early ocv");
		cyc(400);
		chk(out.ocv_enable, 1'b1, "ocv enable");
		chk(out.qmax_update_ok, 1'b1, "qmax ok");
		@(posedge clock);
		meas.volt_slope <= 16'd4;
		cyc(3);
		chk(out.qmax_update_ok, 1'b0, "slope limit");
		mean(16'sd100);
		cyc(15);
		chk(out.relaxed, 1'b1, "early exit");
		mean(16'sd10);
		cyc(3);
		mean(16'sd100);
		cyc(15);
		chk(out.relaxed, 1'b1, "timer restart");
		cyc(30);
		chk(out.relaxed, 1'b0, "relax exit");
		chk(out.ocv_enable, 1'b0, "ocv off");
		pulse(1'b0, 16'sd1234);
		cyc(3);
		chk(out.qmax_a, 16'sd1234, "qmax a learned");
		rchk(32'h24, 32'h1);
		wr(32'h20, {16'd500, 16'd777});
		cyc(3);
		chk(out.qmax_a, 16'sd777, "qmax a host");
		chk(out.qmax_b, 16'sd500, "qmax b host");
		wr(32'h24, 32'hfffffeff);
		rchk(32'h24, 32'h1);
		pulse(1'b1, 16'sd42);
		cyc(3);
		chk(out.qmax_b, 16'sd42, "qmax b learned");
		rchk(32'h24, 32'h101);
		// a write above the decoded window must not alias onto the config
		wr(32'h40, 32'h60);
		rchk(32'h0, 32'h1);
		wr(32'h30, 32'h1234);
		rchk(32'h30, 32'h0);
		rchk(32'h40, 32'h0);
		chk(hresp, 1'b0, "response");
		chk(hreadyout, 1'b1, "ready");
		end_of_test;
	end
endmodule
